// file: design/ufi_consts.svh
// constants for the fifo control and interrupt identification block
// assumes a 32-bit avalon-mm slave with byte addresses
`ifndef UFI_CONSTS_SVH
`define UFI_CONSTS_SVH

// register byte offsets
`define UFI_ADDR_FIFO_CONTROL 5'h00
`define UFI_ADDR_INT_STATUS 5'h04
`define UFI_ADDR_EVT_STATUS 5'h08
`define UFI_ADDR_EVT_CLEAR 5'h0C
`define UFI_ADDR_EVT_ENABLE 5'h10
`define UFI_ADDR_FIFO_STATE 5'h14

// fifo control field positions
`define UFI_FC_ENABLE 0
`define UFI_FC_RX_RESET 1
`define UFI_FC_TX_TRIG_LO 4
`define UFI_FC_RX_TRIG_LO 6

// trigger levels in bytes, by code 0..3
`define UFI_RX_TRIG_0 6'h08
`define UFI_RX_TRIG_1 6'h10
`define UFI_RX_TRIG_2 6'h18
`define UFI_RX_TRIG_3 6'h1C
`define UFI_TX_TRIG_0 6'h10
`define UFI_TX_TRIG_1 6'h08
`define UFI_TX_TRIG_2 6'h18
`define UFI_TX_TRIG_3 6'h1E

// interrupt status codes, bits 5:0
`define UFI_IS_LINE 6'h06
`define UFI_IS_RX_DATA 6'h04
`define UFI_IS_RX_TIMEOUT 6'h0C
`define UFI_IS_TX_EMPTY 6'h02
`define UFI_IS_MODEM 6'h00
`define UFI_IS_XOFF 6'h10
`define UFI_IS_CTS_RTS 6'h20
`define UFI_IS_NONE 6'h01

// reset values
`define UFI_RST_TRIG 2'h0
`define UFI_RST_EVT 7'h00

`endif

// file: design/ufi_pkg.sv
// types for the fifo control and interrupt identification block
// assumes ufi_consts.svh supplies the numeric constants
package ufi_pkg;
    // bus slave states, one-hot
    typedef enum logic [1:0] {
        UFI_ST_IDLE = 2'b01,
        UFI_ST_ACK = 2'b10
    } ufi_bus_state_t;
    // one bit per interrupt source, bit 0 highest priority
    typedef logic [6:0] ufi_src_t;
    typedef logic [1:0] ufi_trig_code_t;
endpackage : ufi_pkg

// file: design/ufi_top.sv
// fifo control and prioritised interrupt identification for one serial channel
// assumes fifo counts and source levels come from logic on clk_i
`timescale 1ns/1ps
`default_nettype none
`include "ufi_consts.svh"

module ufi_top #(
    parameter int COUNT_W = 6
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // fifo side
    input wire logic [COUNT_W-1:0] rx_count_i,
    input wire logic [COUNT_W-1:0] tx_count_i,
    output logic fifo_enable_o,
    output logic rx_fifo_reset_o,
    output logic [COUNT_W-1:0] rx_trigger_level_o,
    output logic [COUNT_W-1:0] tx_trigger_level_o,
    // interrupt source levels
    input wire logic receiver_line_status_i,
    input wire logic rx_timeout_i,
    input wire logic modem_status_i,
    input wire logic xoff_char_i,
    input wire logic cts_rts_change_i,
    // interrupt output
    output logic interrupt_status_valid_o,
    output logic irq_o
);
    import ufi_pkg::*;

    logic rst_ff1;
    logic rst_n;
    ufi_bus_state_t bus_state;
    ufi_trig_code_t rx_trig_code;
    ufi_trig_code_t tx_trig_code;
    ufi_src_t src_now;
    ufi_src_t src_q;
    ufi_src_t evt_status;
    ufi_src_t evt_enable;
    ufi_src_t next_evt_status;
    ufi_src_t next_evt_enable;
    logic [7:0] interrupt_status;
    logic [5:0] next_code;
    logic bus_take;
    logic wr_lane0;
    logic fc_write;
    logic rx_pending;
    logic tx_pending;

    // rx trigger decode, used by the level output and the checks
    function automatic logic [5:0] rx_level(input ufi_trig_code_t code);
        case (code)
            2'h0: rx_level = `UFI_RX_TRIG_0;
            2'h1: rx_level = `UFI_RX_TRIG_1;
            2'h2: rx_level = `UFI_RX_TRIG_2;
            2'h3: rx_level = `UFI_RX_TRIG_3;
            default: rx_level = `UFI_RX_TRIG_0;
        endcase
    endfunction : rx_level

    // tx trigger decode
    function automatic logic [5:0] tx_level(input ufi_trig_code_t code);
        case (code)
            2'h0: tx_level = `UFI_TX_TRIG_0;
            2'h1: tx_level = `UFI_TX_TRIG_1;
            2'h2: tx_level = `UFI_TX_TRIG_2;
            2'h3: tx_level = `UFI_TX_TRIG_3;
            default: tx_level = `UFI_TX_TRIG_0;
        endcase
    endfunction : tx_level

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_ff1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_ff1 <= 1'b1;
            rst_n <= rst_ff1;
        end
    end

    // bus handshake: one wait cycle, request taken when waitrequest is low
    assign bus_take = (avs_read_i | avs_write_i) & ~avs_waitrequest_o;
    assign wr_lane0 = bus_take & avs_write_i & avs_byteenable_i[0];
    assign fc_write = wr_lane0 & (avs_address_i == `UFI_ADDR_FIFO_CONTROL);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            bus_state <= UFI_ST_IDLE;
            avs_waitrequest_o <= 1'b1;
        end else begin
            case (bus_state)
                UFI_ST_IDLE: begin
                    if (avs_read_i | avs_write_i) begin
                        bus_state <= UFI_ST_ACK;
                        avs_waitrequest_o <= 1'b0;
                    end
                end
                UFI_ST_ACK: begin
                    bus_state <= UFI_ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
                default: begin
                    bus_state <= UFI_ST_IDLE;
                    avs_waitrequest_o <= 1'b1;
                end
            endcase
        end
    end

    // read data loaded as waitrequest drops, stands at the taking edge
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata_o <= 32'h0000_0000;
        end else if (bus_state == UFI_ST_IDLE && avs_read_i) begin
            case (avs_address_i)
                `UFI_ADDR_INT_STATUS: avs_readdata_o <= {24'h00_0000, interrupt_status};
                `UFI_ADDR_EVT_STATUS: avs_readdata_o <= {25'h000_0000, evt_status};
                `UFI_ADDR_EVT_ENABLE: avs_readdata_o <= {25'h000_0000, evt_enable};
                `UFI_ADDR_FIFO_STATE: avs_readdata_o <= {24'h00_0000, rx_trig_code, tx_trig_code,
                                                         2'h0, rx_fifo_reset_o, fifo_enable_o};
                // fifo control and event clear are write-only, unmapped reads zero
                default: avs_readdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // fifo enable follows every fifo control write
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            fifo_enable_o <= 1'b0;
        end else if (fc_write) begin
            fifo_enable_o <= avs_writedata_i[`UFI_FC_ENABLE];
        end
    end

    // trigger fields held unless the same write enables the fifos
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_trig_code <= `UFI_RST_TRIG;
            tx_trig_code <= `UFI_RST_TRIG;
        end else if (fc_write && avs_writedata_i[`UFI_FC_ENABLE]) begin
            rx_trig_code <= avs_writedata_i[`UFI_FC_RX_TRIG_LO +: 2];
            tx_trig_code <= avs_writedata_i[`UFI_FC_TX_TRIG_LO +: 2];
        end
    end

    // trigger levels to the fifos, registered
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_trigger_level_o <= COUNT_W'(`UFI_RX_TRIG_0);
            tx_trigger_level_o <= COUNT_W'(`UFI_TX_TRIG_0);
        end else begin
            rx_trigger_level_o <= COUNT_W'(rx_level(rx_trig_code));
            tx_trigger_level_o <= COUNT_W'(tx_level(tx_trig_code));
        end
    end

    // receive fifo reset: one-cycle pulse, the fifo clears in that cycle
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_fifo_reset_o <= 1'b0;
        end else begin
            rx_fifo_reset_o <= fc_write & avs_writedata_i[`UFI_FC_ENABLE] & avs_writedata_i[`UFI_FC_RX_RESET];
        end
    end

    // source levels; with fifos off a single character or empty holding register counts
    assign rx_pending = fifo_enable_o ? (rx_count_i >= rx_trigger_level_o)
                                      : (rx_count_i != '0);
    assign tx_pending = fifo_enable_o ? (tx_count_i < tx_trigger_level_o)
                                      : (tx_count_i == '0);
    assign src_now = {cts_rts_change_i, xoff_char_i, modem_status_i, tx_pending,
                      rx_timeout_i, rx_pending, receiver_line_status_i};

    // priority encoder, first match wins so lower levels stay hidden
    always_comb begin
        next_code = `UFI_IS_NONE;
        if (src_now[0]) begin
            next_code = `UFI_IS_LINE;
        end else if (src_now[2]) begin
            next_code = `UFI_IS_RX_TIMEOUT;
        end else if (src_now[1]) begin
            next_code = `UFI_IS_RX_DATA;
        end else if (src_now[3]) begin
            next_code = `UFI_IS_TX_EMPTY;
        end else if (src_now[4]) begin
            next_code = `UFI_IS_MODEM;
        end else if (src_now[5]) begin
            next_code = `UFI_IS_XOFF;
        end else if (src_now[6]) begin
            next_code = `UFI_IS_CTS_RTS;
        end
    end

    // interrupt status, one cycle behind the sources; bits 7:6 mirror fifo enable
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_status <= {2'h0, `UFI_IS_NONE};
            interrupt_status_valid_o <= 1'b0;
        end else begin
            interrupt_status <= {{2{fifo_enable_o}}, next_code};
            interrupt_status_valid_o <= ~next_code[0];
        end
    end

    // sticky events on rising source levels; a set beats a clear in the same cycle
    always_comb begin
        next_evt_status = evt_status;
        next_evt_enable = evt_enable;
        if (wr_lane0 && avs_address_i == `UFI_ADDR_EVT_CLEAR) begin
            next_evt_status = evt_status & ~avs_writedata_i[6:0];
        end
        if (wr_lane0 && avs_address_i == `UFI_ADDR_EVT_ENABLE) begin
            next_evt_enable = avs_writedata_i[6:0];
        end
        next_evt_status = next_evt_status | (src_now & ~src_q);
    end

    // event registers and interrupt line
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            src_q <= `UFI_RST_EVT;
            evt_status <= `UFI_RST_EVT;
            evt_enable <= `UFI_RST_EVT;
            irq_o <= 1'b0;
        end else begin
            src_q <= src_now;
            evt_status <= next_evt_status;
            evt_enable <= next_evt_enable;
            irq_o <= |(next_evt_status & next_evt_enable);
        end
    end

    // checks
    sequence s_fc_write_enabled;
        fc_write && avs_writedata_i[`UFI_FC_ENABLE];
    endsequence

    sequence s_rx_reset_pulse;
        rx_fifo_reset_o ##1 !rx_fifo_reset_o;
    endsequence

    property p_rx_reset_on_write;
        @(posedge clk_i) disable iff (!rst_n)
        s_fc_write_enabled and (avs_writedata_i[`UFI_FC_RX_RESET] == 1'b1) |=> s_rx_reset_pulse;
    endproperty
    a_rx_reset_on_write: assert property (p_rx_reset_on_write)
        else $error("rx fifo reset did not pulse after write");

    property p_rx_reset_self_clear;
        @(posedge clk_i) disable iff (!rst_n)
        $rose(rx_fifo_reset_o) |=> !rx_fifo_reset_o;
    endproperty
    a_rx_reset_self_clear: assert property (p_rx_reset_self_clear)
        else $error("rx fifo reset bit did not clear itself");

    property p_enable_follows;
        @(posedge clk_i) disable iff (!rst_n)
        fc_write |=> fifo_enable_o == $past(avs_writedata_i[`UFI_FC_ENABLE]);
    endproperty
    a_enable_follows: assert property (p_enable_follows)
        else $error("fifo enable does not follow written bit");

    property p_ignored_when_disabled;
        @(posedge clk_i) disable iff (!rst_n)
        fc_write && !avs_writedata_i[`UFI_FC_ENABLE] |=> $stable(rx_trig_code) && $stable(tx_trig_code)
            && !rx_fifo_reset_o;
    endproperty
    a_ignored_when_disabled: assert property (p_ignored_when_disabled)
        else $error("fifo control bits changed without enable");

    property p_rx_trigger_map;
        @(posedge clk_i) disable iff (!rst_n)
        s_fc_write_enabled ##2 1'b1 |-> rx_trigger_level_o == COUNT_W'(rx_level($past(avs_writedata_i[7:6], 2)));
    endproperty
    a_rx_trigger_map: assert property (p_rx_trigger_map)
        else $error("rx trigger level wrong for code");

    property p_tx_trigger_map;
        @(posedge clk_i) disable iff (!rst_n)
        s_fc_write_enabled ##2 1'b1 |-> tx_trigger_level_o == COUNT_W'(tx_level($past(avs_writedata_i[5:4], 2)));
    endproperty
    a_tx_trigger_map: assert property (p_tx_trigger_map)
        else $error("tx trigger level wrong for code");

    property p_line_status_top;
        @(posedge clk_i) disable iff (!rst_n)
        receiver_line_status_i |=> interrupt_status[5:0] == `UFI_IS_LINE;
    endproperty
    a_line_status_top: assert property (p_line_status_top)
        else $error("line status not reported at top priority");

    property p_rx_data_code;
        @(posedge clk_i) disable iff (!rst_n)
        fifo_enable_o && rx_count_i >= rx_trigger_level_o && !receiver_line_status_i && !rx_timeout_i
            |=> interrupt_status[5:0] == `UFI_IS_RX_DATA;
    endproperty
    a_rx_data_code: assert property (p_rx_data_code)
        else $error("rx data at trigger not reported");

    property p_timeout_over_tx;
        @(posedge clk_i) disable iff (!rst_n)
        rx_timeout_i && !receiver_line_status_i |=> interrupt_status[5:0] == `UFI_IS_RX_TIMEOUT;
    endproperty
    a_timeout_over_tx: assert property (p_timeout_over_tx)
        else $error("rx time-out not reported at level 2");

    property p_tx_empty_code;
        @(posedge clk_i) disable iff (!rst_n)
        fifo_enable_o && tx_count_i < tx_trigger_level_o && src_now[2:0] == 3'h0
            |=> interrupt_status[5:0] == `UFI_IS_TX_EMPTY;
    endproperty
    a_tx_empty_code: assert property (p_tx_empty_code)
        else $error("tx below trigger not reported");

    property p_lowest_alone;
        @(posedge clk_i) disable iff (!rst_n)
        src_now == 7'h40 |=> interrupt_status[5:0] == `UFI_IS_CTS_RTS;
    endproperty
    a_lowest_alone: assert property (p_lowest_alone)
        else $error("cts rts change code wrong");

    property p_none_pending;
        @(posedge clk_i) disable iff (!rst_n)
        src_now == 7'h00 |=> interrupt_status[0] && !interrupt_status_valid_o;
    endproperty
    a_none_pending: assert property (p_none_pending)
        else $error("idle status bit 0 not one");

    property p_set_beats_clear;
        @(posedge clk_i) disable iff (!rst_n)
        (src_now & ~src_q) != 7'h00 |=> (evt_status & $past(src_now & ~src_q)) == $past(src_now & ~src_q);
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("event lost against clear");

endmodule : ufi_top

`default_nettype wire

// file: testbench/ufi_far_model.sv
// far side model: receive and transmit fifo occupancy counters
// assumes the bench pushes receive bytes and loads the transmit count on clk_i
`timescale 1ns/1ps
`default_nettype none

module ufi_far_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic rx_push_i,
    input wire logic tx_load_i,
    input wire logic [5:0] tx_value_i,
    // device side
    input wire logic rx_fifo_reset_i,
    output logic [5:0] rx_count_o,
    output logic [5:0] tx_count_o
);
    // receive fifo stops at 32 bytes, further pushes are lost
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_count_o <= 6'h00;
        end else if (rx_fifo_reset_i) begin
            rx_count_o <= 6'h00;
        end else if (rx_push_i && rx_count_o < 6'h20) begin
            rx_count_o <= rx_count_o + 6'h01;
        end
    end
    // transmit count starts high so no empty event fires out of reset
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_count_o <= 6'h1F;
        end else if (tx_load_i) begin
            tx_count_o <= tx_value_i;
        end
    end
endmodule : ufi_far_model
`default_nettype wire

// file: testbench/ufi_top_tb.sv
// self-checking bench for the fifo control and interrupt identification block
// assumes ufi_top and the far model share one clock and one reset
`timescale 1ns/1ps
`default_nettype none
`include "ufi_consts.svh"

module ufi_top_tb;
    logic clk, rst_n, avs_read, avs_write, rx_push, tx_load;
    logic line, tmo, modem, xoff, cts;
    logic [4:0] avs_address;
    logic [31:0] avs_writedata, readdata, q;
    logic [3:0] avs_byteenable;
    logic [5:0] tx_value, rx_cnt, tx_cnt, rx_lv, tx_lv;
    logic waitreq, fifo_en, rx_rst, valid, irq;
    logic [5:0] rx_tab [4] = '{6'h08, 6'h10, 6'h18, 6'h1C};
    logic [5:0] tx_tab [4] = '{6'h10, 6'h08, 6'h18, 6'h1E};
    logic [5:0] codes [8] = '{6'h06, 6'h0C, 6'h04, 6'h02, 6'h00, 6'h10, 6'h20, 6'h01};
    int n_mismatch = 0;
    int checked = 0;

    ufi_top ufi_top_i (.clk_i(clk), .rst_n_i(rst_n), .avs_address_i(avs_address),
        .avs_read_i(avs_read), .avs_write_i(avs_write), .avs_writedata_i(avs_writedata),
        .avs_byteenable_i(avs_byteenable), .avs_readdata_o(readdata), .avs_waitrequest_o(waitreq),
        .rx_count_i(rx_cnt), .tx_count_i(tx_cnt), .fifo_enable_o(fifo_en), .rx_fifo_reset_o(rx_rst),
        .rx_trigger_level_o(rx_lv), .tx_trigger_level_o(tx_lv), .receiver_line_status_i(line),
        .rx_timeout_i(tmo), .modem_status_i(modem), .xoff_char_i(xoff), .cts_rts_change_i(cts),
        .interrupt_status_valid_o(valid), .irq_o(irq));
    ufi_far_model ufi_far_model_i (.clk_i(clk), .rst_n_i(rst_n), .rx_push_i(rx_push),
        .tx_load_i(tx_load), .tx_value_i(tx_value), .rx_fifo_reset_i(rx_rst),
        .rx_count_o(rx_cnt), .tx_count_o(tx_cnt));

    // free-running clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // one avalon transfer, held until waitrequest is seen low; a hang is left to the watchdog
    task automatic xfer(input logic is_wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_write <= is_wr;
        avs_read <= !is_wr;
        avs_writedata <= d;
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        q = readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : xfer

    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(q, exp);
    endtask : rd_chk

    // sources reach the status register one edge later, a trigger code write two edges after it is taken
    task automatic settle;
        repeat (3) @(posedge clk);
    endtask : settle

    task automatic push(input int n);
        repeat (n) begin
            @(posedge clk);
            rx_push <= 1'b1;
        end
        @(posedge clk);
        rx_push <= 1'b0;
    endtask : push

    task automatic tx_set(input logic [5:0] v);
        @(posedge clk);
        tx_load <= 1'b1;
        tx_value <= v;
        @(posedge clk);
        tx_load <= 1'b0;
    endtask : tx_set

    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        $display("[FAIL] t=%0t watchdog expired", $time);
        end_sim();
    end

    initial begin
        {rst_n, avs_read, avs_write, rx_push, tx_load, line, tmo, modem, xoff, cts} = '0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        tx_value = 6'h00;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // reset state
        chk(fifo_en, 32'h0);
        chk(rx_lv, 32'h08);
        chk(tx_lv, 32'h10);
        rd_chk(`UFI_ADDR_INT_STATUS, 32'h01);
        chk(valid, 32'h0);
        rd_chk(`UFI_ADDR_FIFO_STATE, 32'h00);
        rd_chk(`UFI_ADDR_FIFO_CONTROL, 32'h00);
        rd_chk(5'h18, 32'h00);
        $display("test reset done");
        // every trigger code of both fields
        for (int i = 0; i < 4; i++) begin
            wr(`UFI_ADDR_FIFO_CONTROL, {24'h0, i[1:0], i[1:0], 4'h1});
            settle();
            chk(rx_lv, rx_tab[i]);
            chk(tx_lv, tx_tab[i]);
            rd_chk(`UFI_ADDR_FIFO_STATE, {24'h0, i[1:0], i[1:0], 4'h1});
        end
        // without the enable bit nothing else is programmed
        wr(`UFI_ADDR_FIFO_CONTROL, 32'h02);
        repeat (3) begin
            @(posedge clk);
            chk(rx_rst, 32'h0);
        end
        chk(fifo_en, 32'h0);
        chk(rx_lv, 32'h1C);
        rd_chk(`UFI_ADDR_INT_STATUS, 32'h01);
        $display("test trigger codes done");
        // receive threshold at its boundary, a receive fifo reset, then the transmit threshold
        wr(`UFI_ADDR_FIFO_CONTROL, 32'h01);
        push(7);
        settle();
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hC1);
        push(1);
        settle();
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hC4);
        push(30);
        wr(`UFI_ADDR_FIFO_CONTROL, 32'h03);
        @(posedge clk);
        chk(rx_rst, 32'h1);
        @(posedge clk);
        chk(rx_rst, 32'h0);
        settle();
        rd_chk(`UFI_ADDR_FIFO_STATE, 32'h01);
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hC1);
        tx_set(6'h10);
        settle();
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hC1);
        tx_set(6'h0F);
        settle();
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hC2);
        $display("test thresholds done");
        // all sources pending, serviced from the top down
        push(8);
        {line, tmo, modem, xoff, cts} <= 5'h1F;
        settle();
        for (int i = 0; i < 8; i++) begin
            rd_chk(`UFI_ADDR_INT_STATUS, {24'h0, 2'b11, codes[i]});
            chk(valid, {31'h0, i < 7});
            case (i)
                0: line <= 1'b0;
                1: tmo <= 1'b0;
                2: wr(`UFI_ADDR_FIFO_CONTROL, 32'h03);
                3: tx_set(6'h1F);
                4: modem <= 1'b0;
                5: xoff <= 1'b0;
                6: cts <= 1'b0;
                default: ;
            endcase
            settle();
        end
        $display("test priority done");
        // sticky events, enable mask and clear
        rd_chk(`UFI_ADDR_EVT_STATUS, 32'h7F);
        chk(irq, 32'h0);
        wr(`UFI_ADDR_EVT_ENABLE, 32'h7F);
        settle();
        chk(irq, 32'h1);
        wr(`UFI_ADDR_EVT_CLEAR, 32'h7F);
        settle();
        chk(irq, 32'h0);
        rd_chk(`UFI_ADDR_EVT_STATUS, 32'h00);
        wr(`UFI_ADDR_EVT_ENABLE, 32'h10);
        cts <= 1'b1;
        settle();
        rd_chk(`UFI_ADDR_EVT_STATUS, 32'h40);
        chk(irq, 32'h0);
        wr(`UFI_ADDR_EVT_ENABLE, 32'h50);
        settle();
        chk(irq, 32'h1);
        wr(`UFI_ADDR_EVT_CLEAR, 32'h40);
        settle();
        chk(irq, 32'h0);
        wr(5'h18, 32'hFF);
        // lane 0 disabled, so this enable write must be ignored
        avs_byteenable <= 4'hE;
        wr(`UFI_ADDR_EVT_ENABLE, 32'hFF);
        avs_byteenable <= 4'hF;
        rd_chk(`UFI_ADDR_EVT_ENABLE, 32'h50);
        rd_chk(`UFI_ADDR_INT_STATUS, 32'hE0);
        $display("test events done");
        // second reset in mid-run, cts change still pending
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(fifo_en, 32'h0);
        chk(rx_lv, 32'h08);
        chk(irq, 32'h0);
        rd_chk(`UFI_ADDR_EVT_ENABLE, 32'h00);
        rd_chk(`UFI_ADDR_INT_STATUS, 32'h20);
        $display("test second reset done");
        end_sim();
    end
endmodule : ufi_top_tb
`default_nettype wire
